// >>> shared/clkcfg_regs.svh
// register offsets, field positions, codes and reset values of the channel clock/line block
`ifndef CLKCFG_REGS_SVH
`define CLKCFG_REGS_SVH

`define OFF_CFG 8'h00
`define OFF_CTRL 8'h04
`define OFF_STAT 8'h08
`define OFF_TXDATA 8'h0c
`define OFF_RXDATA 8'h10
`define OFF_DIV 8'h14

`define CFG_W 15
`define CFG_RESET 15'h0007
`define CFG_X4_BIT 14
`define CFG_RXINV_BIT 13
`define CFG_TXINV_BIT 12
`define CFG_RCS_LSB 10
`define CFG_TCS_LSB 7
`define CFG_BCS_LSB 4
`define CFG_CLOCK_ON_REQUEST_TO_SEND_BIT 3
`define CFG_MODE_LSB 0

`define RCS_BRG 2'h0
`define RCS_RXC 2'h1
`define RCS_DIGITAL_CLOCK_RECOVERY_PLL 2'h2

`define TCS_BRG 3'h0
`define TCS_RXC 3'h1
`define TCS_TXC 3'h2
`define TCS_DIGITAL_CLOCK_RECOVERY_PLL 3'h3
`define TCS_BRG16 3'h4

`define BCS_OSC1 3'h0
`define BCS_OSC2 3'h1
`define BCS_OSC3 3'h2
`define BCS_RXC 3'h3
`define BCS_TXC 3'h4

`define MODE_V35 3'h4
`define MODE_V28 3'h6
`define MODE_HIZ 3'h7

`define CTRL_TX_EN_BIT 0
`define CTRL_RX_EN_BIT 1
`define CTRL_TOE_BIT 2
`define CTRL_RTS_BIT 3
`define CTRL_RESET 4'h0

`define STAT_RXV_BIT 0
`define STAT_OVR_BIT 1
`define DIV_RESET 16'h0001

`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

`endif

// >>> shared/clkcfg_pkg.sv
// types shared by the channel clock/line block
package clkcfg_pkg;
  typedef enum logic [1:0] {
    TX_IDLE = 2'b01,
    TX_SHIFT = 2'b10
  } tx_state_t;

  typedef enum logic [3:0] {
    STD_V11 = 4'b0001,
    STD_V35 = 4'b0010,
    STD_V28 = 4'b0100,
    STD_HIZ = 4'b1000
  } line_std_t;
endpackage

// >>> shared/stream_if.sv
// valid/ready word stream between the block and its transmit fifo
`timescale 1ns/1ns
interface stream_if #(parameter int W = 32);
  logic valid;
  logic ready;
  logic [W-1:0] data;
  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface

// >>> rtl/word_fifo.sv
// synchronous word fifo, width and depth as parameters
`timescale 1ns/1ns
module word_fifo #(
  parameter int W = 32,
  parameter int DEPTH = 4
) (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // streams
  stream_if.snk fill,
  stream_if.src drain,
  // level
  output logic [$clog2(DEPTH):0] level
);
  localparam int AW = $clog2(DEPTH);
  logic [W-1:0] mem [DEPTH];
  logic [AW:0] wp_r, wp_nxt, rp_r, rp_nxt;
  logic push, pop;

  always_comb begin
    level = wp_r - rp_r;
    fill.ready = (level != (AW+1)'(DEPTH));
    drain.valid = (level != '0);
    drain.data = mem[rp_r[AW-1:0]];
    push = fill.valid && fill.ready;
    pop = drain.valid && drain.ready;
    wp_nxt = push ? wp_r + 1'b1 : wp_r;
    rp_nxt = pop ? rp_r + 1'b1 : rp_r;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wp_r <= '0;
      rp_r <= '0;
    end else begin
      wp_r <= wp_nxt;
      rp_r <= rp_nxt;
    end
  end

  // storage needs no reset; empty flag hides stale words
  always_ff @(posedge aclk) begin
    if (push) begin
      mem[wp_r[AW-1:0]] <= fill.data;
    end
  end
endmodule

// >>> rtl/chan_clock_line.sv
// per-channel clock source, polarity and line mode configuration with a serial data path
// How it works
// - with the receive invert bit clear data is sampled on the falling receive clock edge, else rising.
// - with the transmit invert bit clear each bit is launched on the rising transmit clock edge, else falling.
// - receive clock field picks generator output, receive clock pin or recovered clock; code 11 is reserved.
// - transmit clock field picks generator, receive pin, transmit pin, recovered clock or generator/16.
// - generator source field picks oscillator one, two, three, the receive clock pin or the transmit clock pin.
// - the clock-on-request-to-send bit puts the transmit clock on the request-to-send pin.
// - the transceiver mode resets to 111, which floats every line driver and receiver.
// - mode 100 gives V.35 data/clock with V.28 handshake, mode 110 gives V.28 on all lines.
// - host accesses are little endian, byte 0 on data bits 7:0 and byte 3 on bits 31:24.
// - lower-addressed bytes of a transmit word go onto the line first.
// - earlier received bytes land in lower byte positions of a receive word.
// - the quadrupler bit multiplies the generator input by four, else it is used as is.
//
// Added by the designer: the register offsets and the AXI4-Lite register port.
`timescale 1ns/1ns
`include "clkcfg_regs.svh"
module chan_clock_line
  import clkcfg_pkg::*;
#(
  parameter int FIFO_DEPTH = 4
) (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // axi4-lite write address and data
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // axi4-lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // axi4-lite read
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // clock sources from outside
  input wire logic osc1_clk,
  input wire logic osc2_clk,
  input wire logic osc3_clk,
  input wire logic digital_clock_recovery_pll_rx_clk,
  input wire logic digital_clock_recovery_pll_tx_clk,
  // serial line pins
  input wire logic rxc_in,
  input wire logic txc_in,
  output logic txc_out,
  output logic txc_oe,
  input wire logic rxd_in,
  output logic txd_out,
  output logic txd_oe,
  output logic rts_out,
  output logic rts_oe,
  // transceiver mode
  output logic [2:0] transceiver_mode_field,
  output line_std_t data_clock_std,
  output line_std_t handshake_std
);
  // sync bit order: 0 osc1, 1 osc2, 2 osc3, 3 rxc, 4 txc, 5 digital_clock_recovery_pll rx, 6 digital_clock_recovery_pll tx, 7 rxd
  logic [7:0] sync1_r, sync2_r;
  logic [`CFG_W-1:0] cfg_r, cfg_nxt;
  logic [3:0] ctrl_r, ctrl_nxt;
  logic [15:0] div_r, div_nxt;
  logic [7:0] awaddr_r, awaddr_nxt;
  logic [31:0] wdata_r, wdata_nxt;
  logic [3:0] wstrb_r, wstrb_nxt;
  logic aw_held_r, aw_held_nxt, w_held_r, w_held_nxt;
  logic awready_r, awready_nxt, wready_r, wready_nxt;
  logic bvalid_r, bvalid_nxt, arready_r, arready_nxt, rvalid_r, rvalid_nxt;
  logic [1:0] bresp_r, bresp_nxt, rresp_r, rresp_nxt;
  logic [31:0] rdata_r, rdata_nxt;
  logic rd_pop, ovr_clr, both_held;
  logic gen_prev_r, gen_prev_nxt, brg_r, brg_nxt, rx_prev_r, rx_prev_nxt;
  logic tx_prev_r, tx_prev_nxt;
  logic [16:0] acc_r, acc_nxt;
  logic [3:0] b16_r, b16_nxt;
  tx_state_t tx_st_r, tx_st_nxt;
  logic [31:0] tsh_r, tsh_nxt, rsh_r, rsh_nxt, rword_r, rword_nxt;
  logic [4:0] tcnt_r, tcnt_nxt, rcnt_r, rcnt_nxt;
  logic rxv_r, rxv_nxt, ovr_r, ovr_nxt;
  logic txd_r, txd_nxt, txc_r, txc_nxt, txc_oe_r, txc_oe_nxt;
  logic rts_r, rts_nxt, lines_oe_r, lines_oe_nxt;
  logic [2:0] mode_r;
  line_std_t dc_std_r, dc_std_nxt, hs_std_r, hs_std_nxt;
  logic [$clog2(FIFO_DEPTH):0] fifo_level;

  stream_if #(.W(32)) fill_s ();
  stream_if #(.W(32)) drain_s ();

  word_fifo #(.W(32), .DEPTH(FIFO_DEPTH)) u_txfifo (
    .aclk(aclk),
    .aresetn(aresetn),
    .fill(fill_s),
    .drain(drain_s),
    .level(fifo_level)
  );

  function automatic logic gen_pick(input logic [2:0] sel, input logic [7:0] s);
    unique case (sel)
      `BCS_OSC1: gen_pick = s[0];
      `BCS_OSC2: gen_pick = s[1];
      `BCS_OSC3: gen_pick = s[2];
      `BCS_RXC: gen_pick = s[3];
      `BCS_TXC: gen_pick = s[4];
      default: gen_pick = 1'b0;
    endcase
  endfunction

  function automatic logic rx_pick(input logic [1:0] sel, input logic baud_rate_generator, input logic [7:0] s);
    unique case (sel)
      `RCS_BRG: rx_pick = baud_rate_generator;
      `RCS_RXC: rx_pick = s[3];
      `RCS_DIGITAL_CLOCK_RECOVERY_PLL: rx_pick = s[5];
      default: rx_pick = 1'b0;
    endcase
  endfunction

  function automatic logic tx_pick(input logic [2:0] sel, input logic baud_rate_generator, input logic b16,
                                   input logic [7:0] s);
    unique case (sel)
      `TCS_BRG: tx_pick = baud_rate_generator;
      `TCS_RXC: tx_pick = s[3];
      `TCS_TXC: tx_pick = s[4];
      `TCS_DIGITAL_CLOCK_RECOVERY_PLL: tx_pick = s[6];
      `TCS_BRG16: tx_pick = b16;
      default: tx_pick = 1'b0;
    endcase
  endfunction

  function automatic line_std_t dc_std(input logic [2:0] m);
    unique case (m)
      `MODE_V35: dc_std = STD_V35;
      `MODE_V28: dc_std = STD_V28;
      `MODE_HIZ: dc_std = STD_HIZ;
      default: dc_std = STD_V11;
    endcase
  endfunction

  // bus slave and registers
  always_comb begin
    cfg_nxt = cfg_r;
    ctrl_nxt = ctrl_r;
    div_nxt = div_r;
    awaddr_nxt = awaddr_r;
    wdata_nxt = wdata_r;
    wstrb_nxt = wstrb_r;
    aw_held_nxt = aw_held_r;
    w_held_nxt = w_held_r;
    bvalid_nxt = bvalid_r;
    bresp_nxt = bresp_r;
    arready_nxt = !rvalid_r;
    rvalid_nxt = rvalid_r;
    rdata_nxt = rdata_r;
    rresp_nxt = rresp_r;
    rd_pop = 1'b0;
    ovr_clr = 1'b0;
    if (s_axi_awvalid && awready_r) begin
      aw_held_nxt = 1'b1;
      awaddr_nxt = s_axi_awaddr;
    end
    if (s_axi_wvalid && wready_r) begin
      w_held_nxt = 1'b1;
      wdata_nxt = s_axi_wdata;
      wstrb_nxt = s_axi_wstrb;
    end
    if (bvalid_r && s_axi_bready) begin
      bvalid_nxt = 1'b0;
    end
    both_held = aw_held_r && w_held_r && !bvalid_r;
    fill_s.valid = both_held && (awaddr_r == `OFF_TXDATA);
    fill_s.data = wdata_r;
    // a full fifo stalls the write response, so the master feels the back-pressure
    if (both_held && (awaddr_r != `OFF_TXDATA || fill_s.ready)) begin
      aw_held_nxt = 1'b0;
      w_held_nxt = 1'b0;
      bvalid_nxt = 1'b1;
      bresp_nxt = `RESP_OKAY;
      unique case (awaddr_r)
        `OFF_CFG: begin
          if (wstrb_r[0]) cfg_nxt[7:0] = wdata_r[7:0];
          if (wstrb_r[1]) cfg_nxt[14:8] = wdata_r[14:8];
        end
        `OFF_CTRL: if (wstrb_r[0]) ctrl_nxt = wdata_r[3:0];
        `OFF_STAT: ovr_clr = wstrb_r[0] && wdata_r[`STAT_OVR_BIT];
        `OFF_DIV: begin
          if (wstrb_r[0]) div_nxt[7:0] = wdata_r[7:0];
          if (wstrb_r[1]) div_nxt[15:8] = wdata_r[15:8];
        end
        `OFF_TXDATA: ;
        default: bresp_nxt = `RESP_SLVERR;
      endcase
    end
    awready_nxt = !aw_held_nxt;
    wready_nxt = !w_held_nxt;
    if (rvalid_r && s_axi_rready) begin
      rvalid_nxt = 1'b0;
      arready_nxt = 1'b1;
    end
    if (s_axi_arvalid && arready_r) begin
      arready_nxt = 1'b0;
      rvalid_nxt = 1'b1;
      rresp_nxt = `RESP_OKAY;
      rdata_nxt = '0;
      unique case (s_axi_araddr)
        `OFF_CFG: rdata_nxt[`CFG_W-1:0] = cfg_r;
        `OFF_CTRL: rdata_nxt[3:0] = ctrl_r;
        `OFF_STAT: rdata_nxt[$clog2(FIFO_DEPTH)+5:0] = {fifo_level, tx_st_r == TX_SHIFT,
                                      !drain_s.valid, !fill_s.ready, ovr_r, rxv_r};
        `OFF_TXDATA: ;
        `OFF_RXDATA: begin
          rdata_nxt = rword_r;
          rd_pop = 1'b1;
        end
        `OFF_DIV: rdata_nxt[15:0] = div_r;
        default: rresp_nxt = `RESP_SLVERR;
      endcase
    end
  end

  // generator, clock selection and serial path
  always_comb begin
    logic gen_in, rx_lvl, tx_lvl, smp, launch;
    logic [16:0] step, divisor;
    {rx_lvl, tx_lvl, smp, launch, step, divisor} = 38'h0;
    gen_in = gen_pick(cfg_r[`CFG_BCS_LSB +: 3], sync2_r);
    gen_prev_nxt = gen_in;
    acc_nxt = acc_r;
    brg_nxt = brg_r;
    b16_nxt = b16_r;
    step = cfg_r[`CFG_X4_BIT] ? 17'h00004 : 17'h00001;
    divisor = (div_r == '0) ? 17'h00001 : {1'b0, div_r};
    if (gen_in && !gen_prev_r) begin
      // a shrunken divisor restarts the count rather than toggling on every edge
      acc_nxt = (acc_r >= divisor) ? 17'h00000 : acc_r + step;
      if (acc_nxt >= divisor) begin
        acc_nxt = acc_nxt - divisor;
        brg_nxt = !brg_r;
      end
    end
    if (brg_nxt && !brg_r) begin
      b16_nxt = b16_r + 4'h1;
    end
    rx_lvl = rx_pick(cfg_r[`CFG_RCS_LSB +: 2], brg_r, sync2_r);
    tx_lvl = tx_pick(cfg_r[`CFG_TCS_LSB +: 3], brg_r, b16_r[3], sync2_r);
    rx_prev_nxt = rx_lvl;
    tx_prev_nxt = tx_lvl;
    smp = cfg_r[`CFG_RXINV_BIT] ? (rx_lvl && !rx_prev_r) : (!rx_lvl && rx_prev_r);
    launch = cfg_r[`CFG_TXINV_BIT] ? (!tx_lvl && tx_prev_r) : (tx_lvl && !tx_prev_r);
    tx_st_nxt = tx_st_r;
    tsh_nxt = tsh_r;
    tcnt_nxt = tcnt_r;
    txd_nxt = txd_r;
    drain_s.ready = 1'b0;
    if (launch) begin
      unique case (tx_st_r)
        TX_IDLE: begin
          txd_nxt = 1'b1;
          if (ctrl_r[`CTRL_TX_EN_BIT] && drain_s.valid) begin
            drain_s.ready = 1'b1;
            txd_nxt = drain_s.data[0];
            tsh_nxt = {1'b0, drain_s.data[31:1]};
            tcnt_nxt = 5'h01;
            tx_st_nxt = TX_SHIFT;
          end
        end
        TX_SHIFT: begin
          if (tcnt_r != 5'h00) begin
            txd_nxt = tsh_r[0];
            tsh_nxt = {1'b0, tsh_r[31:1]};
            tcnt_nxt = tcnt_r + 5'h01;
          end else if (ctrl_r[`CTRL_TX_EN_BIT] && drain_s.valid) begin
            drain_s.ready = 1'b1;
            txd_nxt = drain_s.data[0];
            tsh_nxt = {1'b0, drain_s.data[31:1]};
            tcnt_nxt = 5'h01;
          end else begin
            txd_nxt = 1'b1;
            tx_st_nxt = TX_IDLE;
          end
        end
      endcase
    end
    rsh_nxt = rsh_r;
    rcnt_nxt = rcnt_r;
    rword_nxt = rword_r;
    rxv_nxt = rxv_r;
    ovr_nxt = ovr_r;
    if (rd_pop) rxv_nxt = 1'b0;
    if (ovr_clr) ovr_nxt = 1'b0;
    if (!ctrl_r[`CTRL_RX_EN_BIT]) begin
      rcnt_nxt = 5'h00;
    end else if (smp) begin
      // first bit shifts down to bit 0, so earlier bytes end up lower
      rsh_nxt = {sync2_r[7], rsh_r[31:1]};
      rcnt_nxt = rcnt_r + 5'h01;
      if (rcnt_r == 5'h1f) begin
        rword_nxt = rsh_nxt;
        rxv_nxt = 1'b1; // set beats a read in the same cycle
        if (rxv_r && !rd_pop) ovr_nxt = 1'b1;
      end
    end
    dc_std_nxt = dc_std(cfg_r[`CFG_MODE_LSB +: 3]);
    hs_std_nxt = (cfg_r[`CFG_MODE_LSB +: 3] == `MODE_V35) ? STD_V28 : dc_std_nxt;
    lines_oe_nxt = (cfg_r[`CFG_MODE_LSB +: 3] != `MODE_HIZ);
    txc_nxt = tx_lvl;
    txc_oe_nxt = ctrl_r[`CTRL_TOE_BIT] && lines_oe_nxt;
    rts_nxt = cfg_r[`CFG_CLOCK_ON_REQUEST_TO_SEND_BIT] ? tx_lvl : ctrl_r[`CTRL_RTS_BIT];
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sync1_r <= '0;
      sync2_r <= '0;
      cfg_r <= `CFG_RESET;
      ctrl_r <= `CTRL_RESET;
      div_r <= `DIV_RESET;
      awaddr_r <= '0;
      wdata_r <= '0;
      wstrb_r <= '0;
      aw_held_r <= 1'b0;
      w_held_r <= 1'b0;
      awready_r <= 1'b0;
      wready_r <= 1'b0;
      bvalid_r <= 1'b0;
      bresp_r <= `RESP_OKAY;
      arready_r <= 1'b0;
      rvalid_r <= 1'b0;
      rdata_r <= '0;
      rresp_r <= `RESP_OKAY;
      gen_prev_r <= 1'b0;
      brg_r <= 1'b0;
      acc_r <= '0;
      b16_r <= '0;
      rx_prev_r <= 1'b0;
      tx_prev_r <= 1'b0;
      tx_st_r <= TX_IDLE;
      tsh_r <= '0;
      tcnt_r <= '0;
      rsh_r <= '0;
      rcnt_r <= '0;
      rword_r <= '0;
      rxv_r <= 1'b0;
      ovr_r <= 1'b0;
      txd_r <= 1'b1;
      txc_r <= 1'b0;
      txc_oe_r <= 1'b0;
      rts_r <= 1'b0;
      lines_oe_r <= 1'b0;
      mode_r <= `MODE_HIZ;
      dc_std_r <= STD_HIZ;
      hs_std_r <= STD_HIZ;
    end else begin
      sync1_r <= {rxd_in, digital_clock_recovery_pll_tx_clk, digital_clock_recovery_pll_rx_clk, txc_in, rxc_in, osc3_clk, osc2_clk, osc1_clk};
      sync2_r <= sync1_r;
      cfg_r <= cfg_nxt;
      ctrl_r <= ctrl_nxt;
      div_r <= div_nxt;
      awaddr_r <= awaddr_nxt;
      wdata_r <= wdata_nxt;
      wstrb_r <= wstrb_nxt;
      aw_held_r <= aw_held_nxt;
      w_held_r <= w_held_nxt;
      awready_r <= awready_nxt;
      wready_r <= wready_nxt;
      bvalid_r <= bvalid_nxt;
      bresp_r <= bresp_nxt;
      arready_r <= arready_nxt;
      rvalid_r <= rvalid_nxt;
      rdata_r <= rdata_nxt;
      rresp_r <= rresp_nxt;
      gen_prev_r <= gen_prev_nxt;
      brg_r <= brg_nxt;
      acc_r <= acc_nxt;
      b16_r <= b16_nxt;
      rx_prev_r <= rx_prev_nxt;
      tx_prev_r <= tx_prev_nxt;
      tx_st_r <= tx_st_nxt;
      tsh_r <= tsh_nxt;
      tcnt_r <= tcnt_nxt;
      rsh_r <= rsh_nxt;
      rcnt_r <= rcnt_nxt;
      rword_r <= rword_nxt;
      rxv_r <= rxv_nxt;
      ovr_r <= ovr_nxt;
      txd_r <= txd_nxt;
      txc_r <= txc_nxt;
      txc_oe_r <= txc_oe_nxt;
      rts_r <= rts_nxt;
      lines_oe_r <= lines_oe_nxt;
      mode_r <= cfg_r[`CFG_MODE_LSB +: 3];
      dc_std_r <= dc_std_nxt;
      hs_std_r <= hs_std_nxt;
    end
  end

  assign s_axi_awready = awready_r;
  assign s_axi_wready = wready_r;
  assign s_axi_bvalid = bvalid_r;
  assign s_axi_bresp = bresp_r;
  assign s_axi_arready = arready_r;
  assign s_axi_rvalid = rvalid_r;
  assign s_axi_rdata = rdata_r;
  assign s_axi_rresp = rresp_r;
  assign txd_out = txd_r;
  assign txd_oe = lines_oe_r;
  assign txc_out = txc_r;
  assign txc_oe = txc_oe_r;
  assign rts_out = rts_r;
  assign rts_oe = lines_oe_r;
  assign transceiver_mode_field = mode_r;
  assign data_clock_std = dc_std_r;
  assign handshake_std = hs_std_r;
endmodule

// >>> tb/clk_line_monitor.sv
// concurrent checks on the register bus and line mode outputs of the clock/line block
`timescale 1ns/1ns
module clk_line_monitor
  import clkcfg_pkg::*;
(
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // register bus
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // line side
  input wire logic txd_out,
  input wire logic txd_oe,
  input wire logic txc_oe,
  input wire logic rts_oe,
  input wire logic [2:0] transceiver_mode_field,
  input wire line_std_t data_clock_std,
  input wire line_std_t handshake_std
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  sequence wr_pair;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence rd_take;
    s_axi_arvalid && s_axi_arready;
  endsequence
  // a mode held two cycles has reached every mode output
  hiz_mode_a:
    assert property ($stable(transceiver_mode_field) && transceiver_mode_field == 3'h7 |->
      data_clock_std == STD_HIZ && handshake_std == STD_HIZ && !txd_oe && !txc_oe && !rts_oe)
    else $error("mode 111 leaves a line driven");
  v11_mode_a:
    assert property ($stable(transceiver_mode_field) &&
      transceiver_mode_field inside {3'h0, 3'h1, 3'h2, 3'h3, 3'h5} |->
      data_clock_std == STD_V11 && handshake_std == STD_V11)
    else $error("differential mode wrong");
  v35_mode_a:
    assert property ($stable(transceiver_mode_field) && transceiver_mode_field == 3'h4 |->
      data_clock_std == STD_V35 && handshake_std == STD_V28)
    else $error("mode 100 wrong");
  v28_mode_a:
    assert property ($stable(transceiver_mode_field) && transceiver_mode_field == 3'h6 |->
      data_clock_std == STD_V28 && handshake_std == STD_V28)
    else $error("mode 110 wrong");
  reset_state_a:
    assert property (disable iff (1'b0) !aresetn |=> transceiver_mode_field == 3'h7 &&
      txd_out && !s_axi_bvalid && !s_axi_rvalid)
    else $error("reset state wrong");
  wr_answer_a:
    assert property (wr_pair ##0 s_axi_awaddr != 8'h0c |-> ##2 s_axi_bvalid)
    else $error("write answer late");
  wr_busy_a:
    assert property (wr_pair |=> !s_axi_awready && !s_axi_wready)
    else $error("second write taken");
  b_release_a:
    assert property (s_axi_bvalid && s_axi_bready && !s_axi_awvalid && !s_axi_wvalid |=>
      !s_axi_bvalid)
    else $error("write answer repeated");
  rd_answer_a:
    assert property (rd_take |=> s_axi_rvalid)
    else $error("read answer late");
  rd_release_a:
    assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid && s_axi_arready)
    else $error("read not released");
  bad_read_a:
    assert property (rd_take ##0 s_axi_araddr > 8'h14 |=> s_axi_rresp == 2'h2 &&
      s_axi_rdata == 32'h0)
    else $error("unmapped read answered");
endmodule
bind chan_clock_line clk_line_monitor clk_line_monitor_inst (.*);

// >>> tb/line_partner.sv
// remote line equipment: clocks receive data in and transmit data out
`timescale 1ns/1ns
module line_partner #(
  parameter int HALF = 1000
) (
  // towards the block
  output logic rxc_drv,
  output logic rxd_drv,
  output logic txc_drv,
  // from the block
  input wire logic txd_pin
);
  initial begin
    rxc_drv = 1'b0;
    rxd_drv = 1'b1;
    txc_drv = 1'b0;
  end
  // clocks stand still at the idle level between frames
  task automatic park(input logic inv);
    #10; // step off the aclk edge so the pins never race the sampler
    rxc_drv = inv;
    txc_drv = inv;
    #(HALF);
  endtask
  // data shows only around the sampling edge, so a wrong-edge sampler reads the inverse
  task automatic send_word(input logic [31:0] w, input logic inv);
    for (int i = 0; i < 32; i++) begin
      rxd_drv = ~w[i];
      #(HALF / 2);
      rxc_drv = ~inv;
      #(HALF / 2);
      rxd_drv = w[i];
      #(HALF / 2);
      rxc_drv = inv;
      #(HALF / 2);
    end
    rxd_drv = ~w[31];
  endtask
  task automatic get_word(input logic inv, output logic [31:0] w);
    for (int i = 0; i < 32; i++) begin
      txc_drv = ~inv;
      #(HALF);
      txc_drv = inv;
      w[i] = txd_pin;
      #(HALF);
    end
  endtask
endmodule

// >>> tb/testbench.sv
// self-checking bench for the channel clock/line block
`timescale 1ns/1ns
`include "clkcfg_regs.svh"
module testbench
  import clkcfg_pkg::*;
;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [7:0] s_axi_awaddr = 8'h0, s_axi_araddr = 8'h0;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [31:0] s_axi_rdata;
  logic osc1_clk = 1'b0, osc2_clk = 1'b0, osc3_clk = 1'b0;
  logic digital_clock_recovery_pll_rx_clk = 1'b0, digital_clock_recovery_pll_tx_clk = 1'b0;
  logic rxc_in, txc_in, rxd_in, txc_drv, txc_out, txc_oe, txd_out, txd_oe, rts_out, rts_oe;
  logic [2:0] transceiver_mode_field;
  line_std_t data_clock_std, handshake_std;
  int fail_count = 0;
  int n_tests = 0;
  // rows: cfg, divisor, clock period in ns (0 = no edges), std pair, measure rts
  // the quadrupler row feeds it from a clock inside its allowed band
  logic [31:0] tab [8][5] = '{'{32'h2400, 3, 2400, 8'h11, 0}, '{32'h4011, 8, 2400, 8'h11, 0},
    '{32'h0022, 2, 3200, 8'h11, 0}, '{32'h0203, 1, 12800, 8'h11, 0},
    '{32'h0054, 1, 0, 8'h24, 0}, '{32'h000d, 3, 2400, 8'h11, 1},
    '{32'h0186, 1, 700, 8'h44, 0}, '{32'h0287, 1, 0, 8'h88, 0}};
  logic [31:0] txw [4] = '{32'h1234abcd, 32'h80000001, 32'hfedc0123, 32'h0};
  logic [31:0] rxw [2] = '{32'hc35a0f01, 32'h7ffffffe};

  // clock edges never meet the aclk rising edge, so measured periods are exact
  always #25 aclk = ~aclk;
  always #200 osc1_clk = ~osc1_clk;
  always #300 osc2_clk = ~osc2_clk;
  always #400 osc3_clk = ~osc3_clk;
  always #350 digital_clock_recovery_pll_tx_clk = ~digital_clock_recovery_pll_tx_clk;
  always #450 digital_clock_recovery_pll_rx_clk = ~digital_clock_recovery_pll_rx_clk;
  assign txc_in = txc_oe ? txc_out : txc_drv;

  chan_clock_line chan_clock_line_inst (.*);
  line_partner line_partner_inst (.rxc_drv(rxc_in), .rxd_drv(rxd_in), .txc_drv(txc_drv),
    .txd_pin(txd_out));

  task automatic close_out();
    $display("comparisons %0d mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_tests++;
    if (g !== e) begin
      fail_count++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    int n = 0;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge aclk);
      n++;
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid && n < 400);
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
    if (n >= 400) fail_count++;
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    int n = 0;
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge aclk);
      n++;
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid && n < 400);
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
    if (n >= 400) fail_count++;
  endtask
  task automatic rchk(input string nm, input logic [7:0] a, input logic [31:0] e);
    logic [31:0] d;
    logic [1:0] r;
    rd(a, d, r);
    chk(nm, e, d);
  endtask
  // time between the second and third rising edges, past any switch-over glitch
  task automatic period(input logic use_rts, output logic [31:0] p);
    logic prv, cur;
    int k = 0;
    int n = 0;
    realtime t0 = 0;
    p = 32'h0;
    prv = use_rts ? rts_out : txc_out;
    while (k < 3 && n < 1000) begin
      @(posedge aclk);
      n++;
      cur = use_rts ? rts_out : txc_out;
      if (cur && !prv) begin
        if (k == 2) p = int'($realtime - t0);
        t0 = $realtime;
        k++;
      end
      prv = cur;
    end
  endtask

  initial begin
    #2000000;
    fail_count++;
    close_out();
  end

  initial begin
    logic [31:0] d, p;
    logic [1:0] r;
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    rchk("cfg", `OFF_CFG, 32'h7);
    rchk("ctrl", `OFF_CTRL, 32'h0);
    rchk("stat", `OFF_STAT, 32'h8);
    rchk("div", `OFF_DIV, 32'h1);
    chk("line", 32'h188, {23'h0, txd_out, data_clock_std, handshake_std});
    wr(8'h40, 32'hffff, r);
    chk("bad_wr", 32'h2, {30'h0, r});
    rd(8'h40, d, r);
    chk("bad_rd", 32'h2, {d[29:0], r});
    foreach (tab[i]) begin
      wr(`OFF_DIV, tab[i][1], r);
      wr(`OFF_CFG, tab[i][0], r);
      period(tab[i][4][0], p);
      chk("period", tab[i][2], p);
      rchk("cfg", `OFF_CFG, tab[i][0]);
      chk("mode", tab[i][0][2:0], transceiver_mode_field);
      chk("std", tab[i][3], {data_clock_std, handshake_std});
    end
    s_axi_wstrb <= 4'h1;
    wr(`OFF_CFG, 32'hffffff80, r);
    s_axi_wstrb <= 4'h2;
    wr(`OFF_CFG, 32'h00002100, r);
    s_axi_wstrb <= 4'hf;
    rchk("lanes", `OFF_CFG, 32'h2180);
    wr(`OFF_CFG, 32'h100, r);
    // transmit pin stays an input while it clocks the transmitter
    wr(`OFF_CTRL, 32'h0, r);
    foreach (txw[i]) wr(`OFF_TXDATA, txw[i], r);
    rchk("full", `OFF_STAT, 32'h84);
    wr(`OFF_CTRL, 32'h1, r);
    foreach (txw[i]) begin
      wr(`OFF_CFG, {19'h0, i == 1, 12'h100}, r);
      line_partner_inst.park(i == 1);
      line_partner_inst.get_word(i == 1, d);
      chk("tx_word", txw[i], d);
    end
    for (int k = 0; k < 2; k++) begin
      wr(`OFF_CTRL, 32'h0, r);
      wr(`OFF_CFG, {18'h0, k[0], 13'h400}, r);
      line_partner_inst.park(k[0]);
      wr(`OFF_CTRL, 32'h2, r);
      line_partner_inst.send_word(rxw[k], k[0]);
      repeat (8) @(posedge aclk);
      rd(`OFF_STAT, d, r);
      chk("rx_valid", 32'h1, d[0]);
      rchk("rx_word", `OFF_RXDATA, rxw[k]);
    end
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    rchk("cfg", `OFF_CFG, 32'h7);
    close_out();
  end
endmodule
